/* dv/prqp_rx_queue_sva.sv */
// port assertions for the receive queue pointer block
module prqp_rx_queue_sva (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input prqp_pkg::prqp_rx_in_type rx_in,
	input wire logic rd_consume,
	input prqp_pkg::prqp_ram_wr_type ram_wr,
	input wire logic [6:0] rd_addr,
	input wire logic queue_empty,
	input wire logic queue_full
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_byte_pair;
		ram_wr.en ##1 ram_wr.en;
	endsequence
	AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_RAM_WRITE: assert property (ram_wr.en
		|-> $past(rx_in.byte_valid) && ram_wr.data == $past(rx_in.data))
		else $error("ram write without byte");
	AST_ADDR_STEP: assert property (s_byte_pair
		|-> ram_wr.addr == $past(ram_wr.addr) + 7'h01)
		else $error("write index step wrong");
	AST_READ_STEP: assert property (rd_consume && !queue_empty
		|=> rd_addr == $past(rd_addr) + 7'h01)
		else $error("read index step wrong");
	AST_EMPTY_HOLD: assert property (rd_consume && queue_empty |=> $stable(rd_addr))
		else $error("read index moved while empty");
	AST_RESET_STATE: assert property ($rose(rst_n)
		|-> queue_empty && !queue_full && rd_addr == 7'h00)
		else $error("wrong state after reset");
endmodule
bind prqp_rx_queue prqp_rx_queue_sva prqp_rx_queue_sva_i (.ref_clk, .rst_n, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_in,
	.rd_consume, .ram_wr, .rd_addr, .queue_empty, .queue_full);

/* dv/prqp_rx_queue_tb.sv */
// register and packet path tests of the receive queue block
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module prqp_rx_queue_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] OK = prqp_pkg::RESP_OKAY;
	localparam logic [1:0] ER = prqp_pkg::RESP_SLVERR;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic queue_empty, queue_full, rd_consume;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [6:0] rd_addr;
	prqp_pkg::prqp_rx_in_type rx_in;
	prqp_pkg::prqp_ram_wr_type ram_wr;
	int n_errors = 0;
	int checks = 0;
	logic [13:0] ridx [9] = '{14'h1A4A, 14'h1A4B, 14'h1A4C, 14'h1A4D, 14'h1A50, 14'h1A51,
		14'h1A52, 14'h1A53, 14'h1A54};
	logic [7:0] rval [9] = '{8'h00, 8'h00, 8'h00, 8'h22, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
	always #5 ref_clk = ~ref_clk;
	prqp_rx_queue prqp_rx_queue_i (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.rx_in, .rd_consume, .ram_wr, .rd_addr, .queue_empty, .queue_full);
	prqp_rx_src prqp_rx_src_i (.ref_clk, .rx_in, .rd_consume);
	task automatic wr(input logic [13:0] idx, input logic [7:0] v, input logic [1:0] er);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid);
		// bready stays high, so a back-to-back call never toggles it in one step
		`CHK("bresp", er, s_axi_bresp)
	endtask
	task automatic rd(input logic [13:0] idx, input logic [7:0] ev, input logic [1:0] er);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_arvalid || !s_axi_rvalid);
		`CHK("rresp", er, s_axi_rresp)
		if (er === OK) `CHK("rdata", {24'h000000, ev}, s_axi_rdata)
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (ridx[i]) rd(ridx[i], rval[i], OK);
		rd(14'h1A40, 8'h00, ER);
		wr(14'h1A40, 8'h55, ER);
		wr(14'h1A4D, 8'h10, OK);
		rd(14'h1A4D, 8'h10, OK);
		wr(14'h1A4D, 8'h22, OK);
		wr(14'h1A61, 8'h01, OK);
		prqp_rx_src_i.send(1'b1, 2, 16'hA1B2);
		rd(14'h1A4A, 8'hA1, OK);
		rd(14'h1A4B, 8'hB2, OK);
		rd(14'h1A52, 8'h00, OK);
		wr(14'h1A61, 8'h00, OK);
		prqp_rx_src_i.send(1'b0, 3, 16'h0000);
		rd(14'h1A52, 8'h03, OK);
		rd(14'h1A54, 8'h03, OK);
		`CHK("queue_empty", 1'b0, queue_empty)
		prqp_rx_src_i.consume(4);
		rd(14'h1A51, 8'h80, OK);
		`CHK("rd_addr", 7'h03, rd_addr)
		wr(14'h1A4D, 8'h02, OK);
		prqp_rx_src_i.send(1'b0, 3, 16'h0000);
		rd(14'h1A62, 8'h08, OK);
		rd(14'h1A52, 8'h03, OK);
		prqp_rx_src_i.cut(2);
		rd(14'h1A52, 8'h03, OK);
		wr(14'h1A4D, 8'h22, OK);
		s_axi_wstrb <= 4'h0;
		wr(14'h1A4D, 8'h33, OK);
		s_axi_wstrb <= 4'hF;
		rd(14'h1A4D, 8'h22, OK);
		for (int s = 0; s < 5; s++) prqp_rx_src_i.store_id(3'(s));
		rd(14'h1A4C, 8'h1F, OK);
		wr(14'h1A4C, 8'h04, OK);
		rd(14'h1A4C, 8'h1B, OK);
		wr(14'h1A60, 8'h01, OK);
		rd(14'h1A4C, 8'h00, OK);
		prqp_rx_src_i.store_id(3'h1);
		wr(14'h1A60, 8'h02, OK);
		rd(14'h1A4C, 8'h00, OK);
		wr(14'h1A52, 8'h7F, OK);
		wr(14'h1A54, 8'h7F, OK);
		wr(14'h1A50, 8'h7F, OK);
		`CHK("rd_addr", 7'h03, rd_addr)
		wr(14'h1A51, 8'h00, OK);
		rd(14'h1A51, 8'h82, OK);
		rd(14'h1A53, 8'h02, OK);
		prqp_rx_src_i.send(1'b0, 2, 16'h0000);
		rd(14'h1A53, 8'h01, OK);
		rd(14'h1A52, 8'h01, OK);
		`CHK("queue_full", 1'b0, queue_full)
		prqp_rx_src_i.consume(1);
		rd(14'h1A51, 8'h01, OK);
		prqp_rx_src_i.consume(1);
		rd(14'h1A51, 8'h81, OK);
		wr(14'h1A53, 8'h00, OK);
		rd(14'h1A53, 8'h80, OK);
		`CHK("queue_full", 1'b1, queue_full)
		give_verdict;
	end
	// the tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		give_verdict;
	end
endmodule

/* dv/prqp_rx_src.sv */
// receive packet path model feeding the queue block
module prqp_rx_src (
	input wire logic ref_clk,
	output prqp_pkg::prqp_rx_in_type rx_in,
	output logic rd_consume
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_in = '0;
		rd_consume = 1'b0;
	end
	task automatic send(input logic ack, input int n, input logic [15:0] msg);
		@(posedge ref_clk);
		rx_in.start <= 1'b1;
		rx_in.is_ack <= ack;
		@(posedge ref_clk);
		rx_in.start <= 1'b0;
		for (int k = 0; k < n; k++) begin
			rx_in.byte_valid <= 1'b1;
			rx_in.data <= 8'h40 + 8'(k);
			@(posedge ref_clk);
		end
		rx_in.byte_valid <= 1'b0;
		// idle bytes differ from any sent, so a stale copy shows
		rx_in.data <= 8'hBF;
		rx_in.done <= 1'b1;
		rx_in.ack_msg <= msg;
		@(posedge ref_clk);
		rx_in.done <= 1'b0;
		rx_in.ack_msg <= ~msg;
	endtask
	// packet cut short after n bytes; its bytes must not stay queued
	task automatic cut(input int n);
		@(posedge ref_clk);
		rx_in.start <= 1'b1;
		rx_in.is_ack <= 1'b0;
		@(posedge ref_clk);
		rx_in.start <= 1'b0;
		rx_in.byte_valid <= 1'b1;
		repeat (n) @(posedge ref_clk);
		rx_in.byte_valid <= 1'b0;
		rx_in.abort <= 1'b1;
		@(posedge ref_clk);
		rx_in.abort <= 1'b0;
	endtask
	task automatic consume(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			rd_consume <= 1'b1;
		end
		@(posedge ref_clk);
		rd_consume <= 1'b0;
	endtask
	task automatic store_id(input logic [2:0] sop);
		@(posedge ref_clk);
		rx_in.id_store <= 1'b1;
		rx_in.sop_type <= sop;
		@(posedge ref_clk);
		rx_in.id_store <= 1'b0;
	endtask
endmodule

/* rtl/prqp_pkg.sv */
// constants, types and register map of the receive queue pointer block
// Operation
// - capture acknowledgement high byte, read-only, reset zero
// - capture acknowledgement low byte, read-only, reset zero
// - auto-retry acknowledgements never enter the queue
// - five per-SOP flags set when ID stored
// - writing one clears that SOP's stored ID
// - software or protocol reset clears all flags
// - read/write packet size limit, reset 22h
// - seven-bit read index, reset zero, writable
// - read index write held until aux written
// - empty when packet start equals read index
// - flag read index at slot 127
// - read wrap bit toggles past 127
// - seven-bit write byte index, reset zero
// - full when write byte equals read index
// - flag and wrap toggle for write byte index
// - seven-bit packet start index, reset zero
// - drop oversize packet, set oversize status
package prqp_pkg;
	localparam logic [13:0] IDX_ACK_HIGH = 14'h1A4A;
	localparam logic [13:0] IDX_ACK_LOW = 14'h1A4B;
	localparam logic [13:0] IDX_MSGID = 14'h1A4C;
	localparam logic [13:0] IDX_SIZE_LIMIT = 14'h1A4D;
	localparam logic [13:0] IDX_RD = 14'h1A50;
	localparam logic [13:0] IDX_RD_AUX = 14'h1A51;
	localparam logic [13:0] IDX_WR = 14'h1A52;
	localparam logic [13:0] IDX_WR_AUX = 14'h1A53;
	localparam logic [13:0] IDX_START = 14'h1A54;
	localparam logic [13:0] IDX_RESET_CONTROL_REG = 14'h1A60;
	localparam logic [13:0] IDX_CONFIG = 14'h1A61;
	localparam logic [13:0] IDX_PKT_STATUS = 14'h1A62;
	localparam logic [7:0] SIZE_LIMIT_RESET = 8'h22;
	localparam logic [6:0] PTR_RESET = 7'h00;
	localparam logic [6:0] PTR_ONE = 7'h01;
	localparam logic [6:0] PTR_TOP = 7'h7F;
	localparam logic [7:0] LEN_ONE = 8'h01;
	localparam int FLAG_W = 5;
	localparam int BIT_WRAP = 0;
	localparam int BIT_AT_TOP = 1;
	localparam int BIT_EMPTY_FULL = 7;
	localparam int BIT_SOFTWARE_RESET_CMD = 0;
	localparam int BIT_PROTO_RESET = 1;
	localparam int BIT_AUTO_RETRY = 0;
	localparam int BIT_OVERSIZE = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic start;
		logic is_ack;
		logic byte_valid;
		logic [7:0] data;
		logic done;
		logic abort;
		logic [15:0] ack_msg;
		logic id_store;
		logic [2:0] sop_type;
	} prqp_rx_in_type;

	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} prqp_ram_wr_type;
endpackage

/* rtl/prqp_rx_queue.sv */
// receive queue pointers, acknowledgement capture and ID flags behind AXI4-Lite
module prqp_rx_queue (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input prqp_pkg::prqp_rx_in_type rx_in,
	input wire logic rd_consume,
	output prqp_pkg::prqp_ram_wr_type ram_wr,
	output logic [6:0] rd_addr,
	output logic queue_empty,
	output logic queue_full
);
	typedef enum logic [1:0] {
		PRQP_IDLE,
		PRQP_STORE,
		PRQP_SKIP
	} prqp_state_type;

	prqp_state_type state;
	logic aw_held;
	logic w_held;
	logic [13:0] aw_idx;
	logic [7:0] w_byte;
	logic w_lane0;
	logic wr_do;
	logic wr_hit;
	logic [7:0] ack_high;
	logic [7:0] ack_low;
	logic [4:0] msgid_flags;
	logic [7:0] size_limit;
	logic auto_retry;
	logic oversize;
	logic [6:0] rd_ptr;
	logic rd_wrap;
	logic [6:0] rd_temp;
	logic [6:0] cur_ptr;
	logic cur_wrap;
	logic [6:0] head_ptr;
	logic head_wrap;
	logic [7:0] pkt_len;
	logic sw_clear;
	logic rd_at_top;
	logic cur_at_top;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic [6:0] next_cur;

	// both channels may arrive in either order; held until the write retires
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_do = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			aw_idx <= 14'h0000;
		end else if (s_axi_awvalid && !aw_held) begin
			aw_held <= 1'b1;
			aw_idx <= s_axi_awaddr[15:2];
		end else if (wr_do) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid && !w_held) begin
			w_held <= 1'b1;
			w_byte <= s_axi_wdata[7:0];
			w_lane0 <= s_axi_wstrb[0];
		end else if (wr_do) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		unique case (aw_idx)
			prqp_pkg::IDX_ACK_HIGH, prqp_pkg::IDX_ACK_LOW, prqp_pkg::IDX_MSGID,
			prqp_pkg::IDX_SIZE_LIMIT, prqp_pkg::IDX_RD, prqp_pkg::IDX_RD_AUX,
			prqp_pkg::IDX_WR, prqp_pkg::IDX_WR_AUX, prqp_pkg::IDX_START,
			prqp_pkg::IDX_RESET_CONTROL_REG, prqp_pkg::IDX_CONFIG,
			prqp_pkg::IDX_PKT_STATUS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= prqp_pkg::RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? prqp_pkg::RESP_OKAY : prqp_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// a register write takes effect only through byte lane 0
	function automatic logic sw_write(input logic [13:0] idx);
		sw_write = wr_do && w_lane0 && (aw_idx == idx);
	endfunction

	// software and protocol reset commands are pulses, never stored
	assign sw_clear = sw_write(prqp_pkg::IDX_RESET_CONTROL_REG)
		&& (w_byte[prqp_pkg::BIT_SOFTWARE_RESET_CMD] || w_byte[prqp_pkg::BIT_PROTO_RESET]);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			size_limit <= prqp_pkg::SIZE_LIMIT_RESET;
		end else if (sw_write(prqp_pkg::IDX_SIZE_LIMIT)) begin
			size_limit <= w_byte;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			auto_retry <= 1'b0;
		end else if (sw_write(prqp_pkg::IDX_CONFIG)) begin
			auto_retry <= w_byte[prqp_pkg::BIT_AUTO_RETRY];
		end
	end

	// acknowledgements are captured only in auto-retry mode
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ack_high <= 8'h00;
			ack_low <= 8'h00;
		end else if (rx_in.done && rx_in.is_ack && auto_retry) begin
			ack_high <= rx_in.ack_msg[15:8];
			ack_low <= rx_in.ack_msg[7:0];
		end
	end

	// a new store in the same cycle as a clear wins
	generate
		for (genvar i = 0; i < prqp_pkg::FLAG_W; i++) begin : g_flag
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					msgid_flags[i] <= 1'b0;
				end else if (rx_in.id_store && (rx_in.sop_type == 3'(i))) begin
					msgid_flags[i] <= 1'b1;
				end else if (sw_clear) begin
					msgid_flags[i] <= 1'b0;
				end else if (sw_write(prqp_pkg::IDX_MSGID) && w_byte[i]) begin
					msgid_flags[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign rd_at_top = (rd_ptr == prqp_pkg::PTR_TOP);
	assign cur_at_top = (cur_ptr == prqp_pkg::PTR_TOP);
	assign rd_addr = rd_ptr;
	// wrap bits tell a full lap from an equal index at rest
	assign queue_empty = (head_ptr == rd_ptr) && (head_wrap == rd_wrap);
	assign queue_full = (cur_ptr == rd_ptr) && (cur_wrap != rd_wrap);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_temp <= prqp_pkg::PTR_RESET;
		end else if (sw_write(prqp_pkg::IDX_RD)) begin
			rd_temp <= w_byte[6:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_ptr <= prqp_pkg::PTR_RESET;
			rd_wrap <= 1'b0;
		end else if (sw_write(prqp_pkg::IDX_RD_AUX)) begin
			rd_ptr <= rd_temp;
			rd_wrap <= w_byte[prqp_pkg::BIT_WRAP];
		end else if (rd_consume && !queue_empty) begin
			rd_ptr <= rd_ptr + prqp_pkg::PTR_ONE;
			if (rd_at_top) begin
				rd_wrap <= !rd_wrap;
			end
		end
	end

	assign next_cur = cur_ptr + prqp_pkg::PTR_ONE;

	// software writes to write indexes assume no packet is arriving
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state <= PRQP_IDLE;
			cur_ptr <= prqp_pkg::PTR_RESET;
			cur_wrap <= 1'b0;
			head_ptr <= prqp_pkg::PTR_RESET;
			head_wrap <= 1'b0;
			pkt_len <= 8'h00;
		end else if (sw_write(prqp_pkg::IDX_WR)) begin
			cur_ptr <= w_byte[6:0];
		end else if (sw_write(prqp_pkg::IDX_WR_AUX)) begin
			cur_wrap <= w_byte[prqp_pkg::BIT_WRAP];
		end else if (sw_write(prqp_pkg::IDX_START)) begin
			head_ptr <= w_byte[6:0];
		end else begin
			unique case (state)
				PRQP_IDLE: begin
					if (rx_in.start) begin
						pkt_len <= 8'h00;
						state <= (rx_in.is_ack && auto_retry) ? PRQP_SKIP : PRQP_STORE;
					end
				end
				PRQP_STORE: begin
					if (rx_in.abort) begin
						cur_ptr <= head_ptr;
						cur_wrap <= head_wrap;
						state <= PRQP_IDLE;
					end else if (rx_in.done) begin
						head_ptr <= cur_ptr;
						head_wrap <= cur_wrap;
						state <= PRQP_IDLE;
					end else if (rx_in.byte_valid) begin
						if (pkt_len >= size_limit || queue_full) begin
							// rewind to the packet start
							cur_ptr <= head_ptr;
							cur_wrap <= head_wrap;
							state <= PRQP_SKIP;
						end else begin
							cur_ptr <= next_cur;
							if (cur_at_top) begin
								cur_wrap <= !cur_wrap;
							end
							pkt_len <= pkt_len + prqp_pkg::LEN_ONE;
						end
					end
				end
				PRQP_SKIP: begin
					if (rx_in.done || rx_in.abort) begin
						state <= PRQP_IDLE;
					end
				end
			endcase
		end
	end

	// sticky; a new oversize drop wins over a software clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			oversize <= 1'b0;
		end else if (state == PRQP_STORE && rx_in.byte_valid && !rx_in.done
			&& !rx_in.abort && pkt_len >= size_limit) begin
			oversize <= 1'b1;
		end else if (sw_write(prqp_pkg::IDX_PKT_STATUS) && w_byte[prqp_pkg::BIT_OVERSIZE]) begin
			oversize <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ram_wr <= '0;
		end else begin
			ram_wr.en <= state == PRQP_STORE && rx_in.byte_valid && !rx_in.done
				&& !rx_in.abort && pkt_len < size_limit && !queue_full;
			ram_wr.addr <= cur_ptr;
			ram_wr.data <= rx_in.data;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		unique case (s_axi_araddr[15:2])
			prqp_pkg::IDX_ACK_HIGH: rd_byte = ack_high;
			prqp_pkg::IDX_ACK_LOW: rd_byte = ack_low;
			prqp_pkg::IDX_MSGID: rd_byte = {3'h0, msgid_flags};
			prqp_pkg::IDX_SIZE_LIMIT: rd_byte = size_limit;
			prqp_pkg::IDX_RD: rd_byte = {1'b0, rd_ptr};
			prqp_pkg::IDX_RD_AUX: begin
				rd_byte[prqp_pkg::BIT_EMPTY_FULL] = queue_empty;
				rd_byte[prqp_pkg::BIT_AT_TOP] = rd_at_top;
				rd_byte[prqp_pkg::BIT_WRAP] = rd_wrap;
			end
			prqp_pkg::IDX_WR: rd_byte = {1'b0, cur_ptr};
			prqp_pkg::IDX_WR_AUX: begin
				rd_byte[prqp_pkg::BIT_EMPTY_FULL] = queue_full;
				rd_byte[prqp_pkg::BIT_AT_TOP] = cur_at_top;
				rd_byte[prqp_pkg::BIT_WRAP] = cur_wrap;
			end
			prqp_pkg::IDX_START: rd_byte = {1'b0, head_ptr};
			prqp_pkg::IDX_RESET_CONTROL_REG: rd_byte = 8'h00;
			prqp_pkg::IDX_CONFIG: rd_byte[prqp_pkg::BIT_AUTO_RETRY] = auto_retry;
			prqp_pkg::IDX_PKT_STATUS: rd_byte[prqp_pkg::BIT_OVERSIZE] = oversize;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= prqp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_hit ? prqp_pkg::RESP_OKAY : prqp_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
